//--- verification/brcu_link_model.sv
module brcu_link_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic slow,
	input wire logic din_valid,
	input wire logic [7:0] din_data,
	input wire logic din_last,
	output logic din_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] rx_q[$];
	int last_at;
	logic [1:0] stall_q;
	// Slow mode stalls half the time so held bytes get exercised
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			stall_q <= 2'h0;
			din_ready <= 1'b0;
		end else begin
			stall_q <= stall_q + 2'h1;
			din_ready <= !slow || stall_q[1];
		end
	end
	always @(posedge clk) begin
		if (rst_n && din_valid && din_ready) begin
			rx_q.push_back(din_data);
			if (din_last) last_at = rx_q.size();
		end
	end
endmodule

//--- verification/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	`define CHK(g, e) check_val((g), (e))
	typedef struct {
		logic [7:0] op;
		logic [4:0] mode;
		logic [23:0] off;
		logic [23:0] alloc;
		logic chk;
		logic [7:0] asc;
		int n;
	} brcu_row_t;
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr, slow;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic cmd_valid, cmd_ready, din_valid, din_last, din_ready;
	logic [79:0] cmd_cdb;
	logic [7:0] din_data, sense_asc, echo_wr_data;
	logic done, done_check, echo_wr_valid, echo_wr_first, err;
	logic [3:0] sense_key;
	int failures, checks_done, ncmd;
	brcu_row_t rows[16] = '{
		'{8'h3C, 5'h00, 24'h0, 24'h9, 1'b0, 8'h0, 9},
		'{8'h3C, 5'h02, 24'h200, 24'h5, 1'b0, 8'h0, 5},
		'{8'h3C, 5'h02, 24'h400, 24'h4, 1'b1, 8'h24, 0},
		'{8'h3C, 5'h03, 24'h0, 24'h4, 1'b0, 8'h0, 4},
		'{8'h3C, 5'h03, 24'h0, 24'h0, 1'b0, 8'h0, 0},
		'{8'h3C, 5'h03, 24'h0, 24'h2, 1'b1, 8'h24, 0},
		'{8'h3C, 5'h03, 24'h0, 24'h12C, 1'b0, 8'h0, 4},
		'{8'h3C, 5'h0A, 24'h0, 24'h10009, 1'b0, 8'h0, 6},
		'{8'h3C, 5'h1A, 24'h0, 24'h3, 1'b0, 8'h0, 3},
		'{8'h3C, 5'h0B, 24'h0, 24'h3, 1'b0, 8'h0, 3},
		'{8'h3C, 5'h0B, 24'h4, 24'h4, 1'b1, 8'h24, 0},
		'{8'h3C, 5'h1C, 24'h0, 24'h4, 1'b1, 8'h24, 0},
		'{8'h3C, 5'h01, 24'h0, 24'h4, 1'b1, 8'h24, 0},
		'{8'h3C, 5'h1F, 24'h0, 24'h4, 1'b1, 8'h24, 0},
		'{8'h28, 5'h00, 24'h0, 24'h4, 1'b1, 8'h20, 0},
		'{8'h3C, 5'h0A, 24'h0, 24'h4, 1'b0, 8'h0, 4}
	};

	brcu_top #(.DBUF_AW(10), .ECHO_AW(4)) brcu_top_inst (.clk(clk),
		.rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cmd_valid(cmd_valid), .cmd_cdb(cmd_cdb),
		.cmd_ready(cmd_ready), .din_valid(din_valid), .din_data(din_data),
		.din_last(din_last), .din_ready(din_ready), .done(done),
		.done_check(done_check), .sense_key(sense_key),
		.sense_asc(sense_asc), .echo_wr_valid(echo_wr_valid),
		.echo_wr_first(echo_wr_first), .echo_wr_data(echo_wr_data));
	brcu_link_model brcu_link_model_inst (.clk(clk), .rst_n(rst_n),
		.slow(slow), .din_valid(din_valid), .din_data(din_data),
		.din_last(din_last), .din_ready(din_ready));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic check_val(input logic [63:0] g, input logic [63:0] e);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("ERROR t=%0t got=%0h exp=%0h", $time, g, e);
		end
	endtask

	task automatic stop_test();
		$display("checks=%0d failures=%0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic hang();
		failures++;
		stop_test();
	endtask

	function automatic logic [7:0] dbyte(input int a);
		return 8'(a ^ (a >> 3)) ^ 8'hC3;
	endfunction

	function automatic logic [7:0] exp_byte(input logic [4:0] m,
		input int off, input int i);
		logic [31:0] w;
		case (m)
		5'h00: w = 32'h00000400;
		5'h03: w = 32'h09000400;
		5'h0B: w = 32'h00000010;
		default: w = 32'h0;
		endcase
		if (m == 5'h02) return dbyte(off + i);
		if (m == 5'h00 && i >= 4) return dbyte(i - 4);
		if (m == 5'h0A || m == 5'h1A) return 8'h50 + 8'(i);
		return w[31 - 8 * i -: 8];
	endfunction

	// Request held until pready is seen, released only after that edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		if (k == 20) hang();
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic do_row(input brcu_row_t r);
		int k;
		brcu_link_model_inst.rx_q.delete();
		brcu_link_model_inst.last_at = 0;
		for (k = 0; k < 50; k++) begin
			@(posedge clk);
			if (cmd_ready === 1'b1) break;
		end
		if (k == 50) hang();
		cmd_cdb <= {r.op, 3'h0, r.mode, 8'h00, r.off, r.alloc, 8'h00};
		cmd_valid <= 1'b1;
		@(posedge clk);
		cmd_valid <= 1'b0;
		ncmd++;
		for (k = 0; k < 400; k++) begin
			@(posedge clk);
			if (done === 1'b1) break;
		end
		if (k == 400) hang();
		`CHK(done_check, r.chk);
		`CHK(sense_key, r.chk ? 4'h5 : 4'h0);
		`CHK(sense_asc, r.asc);
		`CHK(brcu_link_model_inst.rx_q.size(), r.n);
		`CHK(brcu_link_model_inst.last_at, r.n);
		for (k = 0; k < r.n; k++) begin
			`CHK(brcu_link_model_inst.rx_q[k], exp_byte(r.mode, r.off, k));
		end
	endtask

	initial begin
		int i;
		{rst_n, psel, penable, pwrite, cmd_valid, slow} = 6'h0;
		{echo_wr_valid, echo_wr_first, echo_wr_data} = 10'h0;
		{paddr, pwdata, cmd_cdb} = 124'h0;
		failures = 0;
		checks_done = 0;
		ncmd = 0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		`CHK({cmd_ready, din_valid, done, pready}, 4'h0);
		apb(1'b0, brcu_pkg::REG_STATUS, 32'h0);
		`CHK(rd, 32'h0);
		// Reads before any echo write must be refused
		do_row('{8'h3C, 5'h0A, 24'h0, 24'h4, 1'b1, 8'h2C, 0});
		do_row('{8'h3C, 5'h1A, 24'h0, 24'h4, 1'b1, 8'h2C, 0});
		for (i = 0; i < 6; i++) begin
			@(posedge clk);
			echo_wr_valid <= 1'b1;
			echo_wr_first <= (i == 0);
			echo_wr_data <= 8'h50 + 8'(i);
		end
		@(posedge clk);
		echo_wr_valid <= 1'b0;
		apb(1'b0, brcu_pkg::REG_STATUS, 32'h0);
		`CHK(rd, 32'h00062C52);
		apb(1'b1, brcu_pkg::REG_WPTR, 32'h0);
		for (i = 0; i < 8; i++) apb(1'b1, brcu_pkg::REG_WDATA, dbyte(i));
		apb(1'b1, brcu_pkg::REG_WPTR, 32'h200);
		for (i = 0; i < 8; i++) apb(1'b1, brcu_pkg::REG_WDATA, dbyte(512 + i));
		apb(1'b1, brcu_pkg::REG_FILL, 32'h258);
		apb(1'b0, brcu_pkg::REG_FILL, 32'h0);
		`CHK(rd, 32'h258);
		for (i = 0; i < 16; i++) begin
			slow <= i[0];
			do_row(rows[i]);
		end
		// Small fill caps the combined transfer below the allocation
		apb(1'b1, brcu_pkg::REG_FILL, 32'h3);
		do_row('{8'h3C, 5'h00, 24'h0, 24'h64, 1'b0, 8'h0, 7});
		// Full echo descriptor so the capacity byte is seen
		do_row('{8'h3C, 5'h0B, 24'h0, 24'h8, 1'b0, 8'h0, 4});
		apb(1'b0, 12'h020, 32'h0);
		`CHK({err, rd}, 33'h100000000);
		apb(1'b0, brcu_pkg::REG_COUNT, 32'h0);
		`CHK(rd[15:0], 16'(ncmd));
		// Mid-run reset must forget that the echo buffer was written
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		`CHK({cmd_ready, din_valid, done, sense_key, sense_asc}, 15'h0);
		do_row('{8'h3C, 5'h0A, 24'h0, 24'h4, 1'b1, 8'h2C, 0});
		apb(1'b0, brcu_pkg::REG_COUNT, 32'h0);
		`CHK(rd[15:0], 16'h0001);
		stop_test();
	end
endmodule

//--- verilog/brcu_mem.sv
module brcu_mem #(
	parameter int WIDTH = 8,
	parameter int AW = 10
) (
	input wire logic clk,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic [AW-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);
	logic [WIDTH-1:0] mem [2**AW];

	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// Registered read keeps the output path short
	always_ff @(posedge clk) begin
		rd_data <= mem[rd_addr];
	end
endmodule

//--- verilog/brcu_pkg.sv
package brcu_pkg;
	localparam logic [7:0] OPC_READBACK = 8'h3C;
	localparam int CDB_W = 80;
	localparam int OP_LSB = 72;
	localparam int MODE_LSB = 64;
	localparam int OFF_LSB = 32;
	localparam int ALLOC_LSB = 8;

	typedef enum logic [4:0] {
		MODE_HDR_DATA = 5'h00,
		MODE_DATA = 5'h02,
		MODE_DESC = 5'h03,
		MODE_ECHO = 5'h0A,
		MODE_ECHO_DESC = 5'h0B,
		MODE_EXP_ECHO = 5'h1A,
		MODE_ERR_HIST = 5'h1C
	} brcu_mode_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_FETCH = 3'b001,
		ST_WAIT = 3'b010,
		ST_SHOW = 3'b011,
		ST_DONE = 3'b100
	} brcu_state_t;

	localparam logic [3:0] SK_NONE = 4'h0;
	localparam logic [3:0] SK_ILLEGAL = 4'h5;
	localparam logic [7:0] ASC_NONE = 8'h00;
	localparam logic [7:0] ASC_BAD_OPCODE = 8'h20;
	localparam logic [7:0] ASC_BAD_FIELD = 8'h24;
	localparam logic [7:0] ASC_SEQ_ERR = 8'h2C;
	localparam logic [2:0] HDR_LEN = 3'h4;
	localparam logic [23:0] DESC_LEN = 24'h000004;
	localparam logic [7:0] OFS_BOUNDARY = 8'h09;
	localparam logic echo_overwrite_support_flag = 1'b0;

	localparam logic [11:0] REG_FILL = 12'h000;
	localparam logic [11:0] REG_WPTR = 12'h004;
	localparam logic [11:0] REG_WDATA = 12'h008;
	localparam logic [11:0] REG_STATUS = 12'h00C;
	localparam logic [11:0] REG_COUNT = 12'h010;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_ECHO_BIT = 1;
	localparam int ST_KEY_LSB = 4;
	localparam int ST_ASC_LSB = 8;
	localparam int ST_ELEN_LSB = 16;
	localparam logic [15:0] COUNT_RST = 16'h0000;
	localparam logic [31:0] PRDATA_RST = 32'h00000000;
endpackage

//--- verilog/brcu_top.sv
// Behaviour
// - Opcode 3Ch selects read-back; mode decides field meaning
// - Modes: 00h, 02h, 03h, 0Ah, 0Bh, 1Ah; others, 1Ch included, unsupported
// - Only internal buffers are touched, never the medium
// - Combined mode sends 4-byte header then data; selector, offset ignored
// - Combined mode stops at min of allocation and header plus data
// - Header capacity is full buffer size, never reduced
// - Data mode returns from offset, min of allocation and available
// - Data mode offset past buffer gives illegal request, invalid field
// - Descriptor mode returns up to four bytes; zero allocation sends none
// - Descriptor allocation one to three is rejected as invalid field
// - Offset boundary exponent always reported as nine
// - Echo mode returns bytes written earlier in echo mode
// - Echo read before any echo write ends with illegal request
// - Echo mode uses allocation low byte only; min with written count
// - Echo buffer is storage apart from the data buffer
// - Echo descriptor needs zero offset; up to four bytes returned
// - Echo descriptor overwrite-support flag reads zero
// - Echo descriptor capacity is echo size aligned to four bytes
// - Expander communications mode behaves as echo data read
module brcu_top #(
	parameter int DBUF_AW = 10,
	parameter int ECHO_AW = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic cmd_valid,
	input wire logic [79:0] cmd_cdb,
	output logic cmd_ready,
	output logic din_valid,
	output logic [7:0] din_data,
	output logic din_last,
	input wire logic din_ready,
	output logic done,
	output logic done_check,
	output logic [3:0] sense_key,
	output logic [7:0] sense_asc,
	input wire logic echo_wr_valid,
	input wire logic echo_wr_first,
	input wire logic [7:0] echo_wr_data
);
	localparam logic [23:0] DCAP = 24'(2**DBUF_AW);
	localparam logic [12:0] ECAP = 13'((2**ECHO_AW) & ~3);
	localparam logic [ECHO_AW:0] EDEPTH = (ECHO_AW+1)'(2**ECHO_AW);

	if (DBUF_AW < 2 || DBUF_AW > 23) begin : g_chk_dbuf
		$error("DBUF_AW out of range");
	end
	if (ECHO_AW < 2 || ECHO_AW > 12) begin : g_chk_echo
		$error("ECHO_AW out of range");
	end

	brcu_pkg::brcu_state_t state_q;
	logic cmd_ready_q, din_valid_q, din_last_q, done_q, check_q, done_check_q;
	logic [7:0] din_data_q, asc_q;
	logic [3:0] key_q;
	logic [4:0] mode_q;
	logic [23:0] total_q, idx_q, base_q;
	logic [31:0] fixed_q;
	logic [2:0] flen_q;
	logic echo_sel_q, echo_valid_q;
	logic [ECHO_AW:0] elen_q;
	logic [DBUF_AW:0] fill_q;
	logic [DBUF_AW-1:0] wptr_q;
	logic [15:0] count_q;
	logic pready_q, pslverr_q;
	logic [31:0] prdata_q;

	logic [7:0] c_op;
	logic [4:0] c_mode;
	logic [23:0] c_off, c_alloc, fill_ext, elen_ext;
	logic d_err;
	logic [7:0] d_asc;
	logic [23:0] d_total, d_base;
	logic [31:0] d_fixed;
	logic [2:0] d_flen;
	logic d_echo;
	logic accept, last_byte, apb_wr, dbuf_we, echo_we;
	logic [23:0] rd_ptr;
	logic [7:0] drd, erd;
	logic [ECHO_AW-1:0] echo_waddr;

	function automatic logic [23:0] min24(input logic [23:0] a,
			input logic [23:0] b);
		min24 = (a < b) ? a : b;
	endfunction

	assign c_op = cmd_cdb[brcu_pkg::OP_LSB +: 8];
	assign c_mode = cmd_cdb[brcu_pkg::MODE_LSB +: 5];
	assign c_off = cmd_cdb[brcu_pkg::OFF_LSB +: 24];
	assign c_alloc = cmd_cdb[brcu_pkg::ALLOC_LSB +: 24];
	assign fill_ext = 24'(fill_q);
	assign elen_ext = 24'(elen_q);
	assign accept = cmd_valid && cmd_ready_q
		&& state_q == brcu_pkg::ST_IDLE;
	assign last_byte = (24'(idx_q + 24'h000001) == total_q);

	// Command decode; the result is latched only on accept
	always_comb begin
		d_err = 1'b0;
		d_asc = brcu_pkg::ASC_BAD_FIELD;
		d_total = 24'h000000;
		d_base = 24'h000000;
		d_fixed = 32'h00000000;
		d_flen = 3'h0;
		d_echo = 1'b0;
		if (c_op != brcu_pkg::OPC_READBACK) begin
			d_err = 1'b1;
			d_asc = brcu_pkg::ASC_BAD_OPCODE;
		end else begin
			case (c_mode)
				brcu_pkg::MODE_HDR_DATA: begin
					// Selector and offset deliberately unused
					d_fixed = {8'h00, DCAP};
					d_flen = brcu_pkg::HDR_LEN;
					d_total = min24(c_alloc,
						24'(fill_ext + 24'(brcu_pkg::HDR_LEN)));
				end
				brcu_pkg::MODE_DATA: begin
					// Selector assumed zero by the initiator
					if (c_off >= DCAP) begin
						d_err = 1'b1;
					end else begin
						d_base = c_off;
						d_total = min24(c_alloc, (fill_ext > c_off)
							? 24'(fill_ext - c_off) : 24'h000000);
					end
				end
				brcu_pkg::MODE_DESC: begin
					if (c_alloc != 24'h000000
							&& c_alloc < brcu_pkg::DESC_LEN) begin
						d_err = 1'b1;
					end else begin
						d_fixed = {brcu_pkg::OFS_BOUNDARY, DCAP};
						d_flen = brcu_pkg::HDR_LEN;
						d_total = min24(c_alloc, brcu_pkg::DESC_LEN);
					end
				end
				brcu_pkg::MODE_ECHO, brcu_pkg::MODE_EXP_ECHO: begin
					if (!echo_valid_q) begin
						d_err = 1'b1;
						d_asc = brcu_pkg::ASC_SEQ_ERR;
					end else begin
						d_echo = 1'b1;
						d_total = min24({16'h0000, c_alloc[7:0]},
							elen_ext);
					end
				end
				brcu_pkg::MODE_ECHO_DESC: begin
					if (c_off != 24'h000000) begin
						d_err = 1'b1;
					end else begin
						d_fixed = {7'h00, brcu_pkg::echo_overwrite_support_flag,
							8'h00, 3'h0, ECAP};
						d_flen = brcu_pkg::HDR_LEN;
						d_total = min24(c_alloc, brcu_pkg::DESC_LEN);
					end
				end
				default: begin
					// Error history is not served here
					d_err = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q <= brcu_pkg::ST_IDLE;
		end else begin
			case (state_q)
				brcu_pkg::ST_IDLE: begin
					if (accept) begin
						state_q <= (d_err || d_total == 24'h000000)
							? brcu_pkg::ST_DONE : brcu_pkg::ST_FETCH;
					end
				end
				brcu_pkg::ST_FETCH: state_q <= brcu_pkg::ST_WAIT;
				brcu_pkg::ST_WAIT: state_q <= brcu_pkg::ST_SHOW;
				brcu_pkg::ST_SHOW: begin
					if (din_ready) begin
						state_q <= last_byte ? brcu_pkg::ST_DONE
							: brcu_pkg::ST_FETCH;
					end
				end
				default: state_q <= brcu_pkg::ST_IDLE;
			endcase
		end
	end

	// Per-command context
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mode_q <= 5'h00;
			total_q <= 24'h000000;
			base_q <= 24'h000000;
			flen_q <= 3'h0;
			echo_sel_q <= 1'b0;
			key_q <= brcu_pkg::SK_NONE;
			asc_q <= brcu_pkg::ASC_NONE;
			check_q <= 1'b0;
		end else if (accept) begin
			mode_q <= c_mode;
			total_q <= d_err ? 24'h000000 : d_total;
			base_q <= d_base;
			flen_q <= d_flen;
			echo_sel_q <= d_echo;
			check_q <= d_err;
			key_q <= d_err ? brcu_pkg::SK_ILLEGAL : brcu_pkg::SK_NONE;
			asc_q <= d_err ? d_asc : brcu_pkg::ASC_NONE;
		end
	end

	// Fixed bytes leave from the top of a shifter
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			fixed_q <= 32'h00000000;
			idx_q <= 24'h000000;
		end else if (accept) begin
			fixed_q <= d_fixed;
			idx_q <= 24'h000000;
		end else if (state_q == brcu_pkg::ST_SHOW && din_ready) begin
			fixed_q <= {fixed_q[23:0], 8'h00};
			idx_q <= 24'(idx_q + 24'h000001);
		end
	end

	assign rd_ptr = 24'(base_q + idx_q - 24'(flen_q));

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			din_valid_q <= 1'b0;
			din_data_q <= 8'h00;
			din_last_q <= 1'b0;
		end else if (state_q == brcu_pkg::ST_WAIT) begin
			din_valid_q <= 1'b1;
			din_last_q <= last_byte;
			if (idx_q < 24'(flen_q)) begin
				din_data_q <= fixed_q[31:24];
			end else begin
				din_data_q <= echo_sel_q ? erd : drd;
			end
		end else if (state_q == brcu_pkg::ST_SHOW && din_ready) begin
			din_valid_q <= 1'b0;
			din_last_q <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cmd_ready_q <= 1'b0;
			done_q <= 1'b0;
			done_check_q <= 1'b0;
		end else begin
			done_q <= (state_q == brcu_pkg::ST_DONE);
			done_check_q <= (state_q == brcu_pkg::ST_DONE) && check_q;
			if (accept) begin
				cmd_ready_q <= 1'b0;
			end else if (state_q == brcu_pkg::ST_IDLE
					|| state_q == brcu_pkg::ST_DONE) begin
				cmd_ready_q <= 1'b1;
			end
		end
	end

	// Echo fill; a new first byte restarts the length
	assign echo_we = echo_wr_valid && (echo_wr_first || elen_q < EDEPTH);
	assign echo_waddr = echo_wr_first ? '0 : elen_q[ECHO_AW-1:0];

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			elen_q <= '0;
			echo_valid_q <= 1'b0;
		end else if (echo_we) begin
			elen_q <= echo_wr_first ? (ECHO_AW+1)'(1)
				: (ECHO_AW+1)'(elen_q + 1'b1);
			echo_valid_q <= 1'b1;
		end
	end

	// Separate arrays; nothing here reaches the medium
	brcu_mem #(.WIDTH(8), .AW(DBUF_AW)) u_dbuf (
		.clk(clk),
		.wr_en(dbuf_we),
		.wr_addr(wptr_q),
		.wr_data(pwdata[7:0]),
		.rd_addr(rd_ptr[DBUF_AW-1:0]),
		.rd_data(drd)
	);

	brcu_mem #(.WIDTH(8), .AW(ECHO_AW)) u_ebuf (
		.clk(clk),
		.wr_en(echo_we),
		.wr_addr(echo_waddr),
		.wr_data(echo_wr_data),
		.rd_addr(rd_ptr[ECHO_AW-1:0]),
		.rd_data(erd)
	);

	// APB slave: one wait state, so pready is a flop
	assign apb_wr = psel && penable && pready_q && pwrite;
	assign dbuf_we = apb_wr && paddr == brcu_pkg::REG_WDATA;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= brcu_pkg::PRDATA_RST;
		end else begin
			pready_q <= psel && penable && !pready_q;
			pslverr_q <= 1'b0;
			prdata_q <= brcu_pkg::PRDATA_RST;
			if (psel && penable && !pready_q) begin
				if (paddr == brcu_pkg::REG_FILL) begin
					prdata_q <= 32'(fill_q);
				end else if (paddr == brcu_pkg::REG_WPTR) begin
					prdata_q <= 32'(wptr_q);
				end else if (paddr == brcu_pkg::REG_WDATA) begin
					prdata_q <= brcu_pkg::PRDATA_RST;
				end else if (paddr == brcu_pkg::REG_STATUS) begin
					prdata_q[brcu_pkg::ST_BUSY_BIT] <=
						(state_q != brcu_pkg::ST_IDLE);
					prdata_q[brcu_pkg::ST_ECHO_BIT] <= echo_valid_q;
					prdata_q[brcu_pkg::ST_KEY_LSB +: 4] <= key_q;
					prdata_q[brcu_pkg::ST_ASC_LSB +: 8] <= asc_q;
					prdata_q[brcu_pkg::ST_ELEN_LSB +: 16] <= 16'(elen_q);
				end else if (paddr == brcu_pkg::REG_COUNT) begin
					prdata_q <= {16'h0000, count_q};
				end else begin
					pslverr_q <= 1'b1;
				end
			end
		end
	end

	// Fill above capacity saturates so available data stays honest
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			fill_q <= '0;
			wptr_q <= '0;
		end else if (apb_wr) begin
			if (paddr == brcu_pkg::REG_FILL) begin
				fill_q <= (pwdata > 32'(DCAP)) ? (DBUF_AW+1)'(DCAP)
					: pwdata[DBUF_AW:0];
			end else if (paddr == brcu_pkg::REG_WPTR) begin
				wptr_q <= pwdata[DBUF_AW-1:0];
			end else if (paddr == brcu_pkg::REG_WDATA) begin
				wptr_q <= DBUF_AW'(wptr_q + 1'b1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			count_q <= brcu_pkg::COUNT_RST;
		end else if (accept) begin
			count_q <= 16'(count_q + 16'h0001);
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign cmd_ready = cmd_ready_q;
	assign din_valid = din_valid_q;
	assign din_data = din_data_q;
	assign din_last = din_last_q;
	assign done = done_q;
	assign done_check = done_check_q;
	assign sense_key = key_q;
	assign sense_asc = asc_q;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_accept;
		cmd_valid && cmd_ready_q && state_q == brcu_pkg::ST_IDLE;
	endsequence

	sequence s_reject(logic [7:0] code);
		!din_valid_q ##1 (done_q && check_q
			&& key_q == brcu_pkg::SK_ILLEGAL && asc_q == code);
	endsequence

	a_bad_opcode: assert property (s_accept ##0 (c_op != 8'h3C)
		|-> ##1 s_reject(8'h20)) else $error("opcode not refused");
	a_unsup_mode: assert property (s_accept ##0 (c_op == 8'h3C
		&& (c_mode == 5'h01 || c_mode == 5'h1C || c_mode == 5'h1F))
		|-> ##1 s_reject(8'h24)) else $error("mode not refused");
	a_desc_short: assert property (s_accept ##0 (c_op == 8'h3C
		&& c_mode == 5'h03 && c_alloc inside {[1:3]})
		|-> ##1 s_reject(8'h24)) else $error("short alloc kept");
	a_data_offset: assert property (s_accept ##0 (c_op == 8'h3C
		&& c_mode == 5'h02 && c_off >= DCAP)
		|-> ##1 s_reject(8'h24)) else $error("offset not refused");
	a_echo_unwritten: assert property (s_accept ##0 (c_op == 8'h3C
		&& c_mode == 5'h0A && !echo_valid_q)
		|-> ##1 s_reject(8'h2C)) else $error("echo early");
	a_alloc_zero: assert property (s_accept ##0 (c_op == 8'h3C
		&& c_mode == 5'h03 && c_alloc == 24'h0)
		|-> !din_valid_q [*2] ##1 (done_q && !check_q))
		else $error("zero alloc sent data");
	a_hdr_capacity: assert property (din_valid_q && mode_q == 5'h00
		&& idx_q == 24'h2 |-> din_data_q == DCAP[15:8])
		else $error("header capacity wrong");
	a_boundary_nine: assert property (din_valid_q
		&& mode_q == 5'h03 && idx_q == 24'h0 |-> din_data_q == 8'h09)
		else $error("boundary not nine");
	a_echo_ovw_zero: assert property (din_valid_q
		&& mode_q == 5'h0B && idx_q == 24'h0 |-> din_data_q[0] == 1'b0)
		else $error("overwrite flag set");
	a_echo_cap: assert property (din_valid_q && mode_q == 5'h0B
		&& idx_q == 24'h3 |-> din_data_q == ECAP[7:0])
		else $error("echo capacity wrong");
	a_last_count: assert property (din_valid_q && din_ready
		&& din_last_q |=> !din_valid_q ##1 done_q)
		else $error("transfer end wrong");
	a_data_hold: assert property (din_valid_q && !din_ready
		|=> din_valid_q && $stable(din_data_q))
		else $error("data dropped");
endmodule
